/* File: verilog/scs_top.sv */
/*
   Standby cause and control: records why Standby was last entered, holds the
   power-now bit, sequences Working and Standby with the abnormal return delay.
   Assumes event and wake inputs and the 32 kHz clock come from pins; the
   planned sleep request is a one-cycle strobe on the local clock.
*/
// Our own choices: the register offsets and the strobed register port.
// How it works
// - Reserved status bits read zero, writes ignored
// - Bit 18 reads power-now, writes ignored
// - Write one bit 17 clears power-now unless bit 16 is also one
// - Write one bit 16 sets power-now
// - Bit 12 bad packet, return after delay
// - Bit 11 control soft reset, return after delay
// - Bit 10 watchdog reset, return after delay
// - Bit 9 shutdown reset, return after delay
// - Bit 8 software reset, return after delay
// - Bit 6 hard reset, needs release plus delay
// - Bit 5 low battery, default wakeup
// - Bit 4 thermal, default wakeup
// - Bit 3 button hold, default wakeup
// - Bit 2 supply loss, default wakeup
// - Bit 1 planned sleep, programmed wakeup
// - Bit 0 standby domain reset, default wakeup
// - Entry clears all flags but its cause
// - Writing one clears a cause flag
// - Reset-type entries keep power enables high
// - Abnormal entry waits delay in 32 kHz edges
`timescale 1ns/1ns
module scs_top #(
   parameter int DELAY_W = scs_pkg::SCS_DLY_W
) (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_b,
   input  wire logic [7:0]         i_addr,
   input  wire logic [31:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic      [31:0]        o_rdata,
   input  wire scs_pkg::scs_events_t i_events,
   input  wire logic               i_planned_sleep,
   input  wire logic               i_slow_clk,
   input  wire logic               i_wake_default,
   input  wire logic               i_wake_programmed,
   output logic                    o_working_en,
   output logic                    o_work_aux_en,
   output logic                    o_standby,
   output logic                    o_power_now,
   output logic [12:0]             o_last_cause
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int SW = $bits(scs_pkg::scs_events_t) + 3;

   scs_pkg::scs_events_t ev_lvl;
   scs_pkg::scs_events_t ev_prev_r;
   scs_pkg::scs_events_t ev_rise;
   logic [SW-1:0]        sync_in;
   logic [SW-1:0]        sync_out;
   logic                 slow_lvl;
   logic                 slow_prev_r;
   logic                 slow_tick;
   logic                 wake_def_lvl;
   logic                 wake_prg_lvl;
   scs_pkg::scs_state_t  state_r;
   scs_pkg::scs_state_t  state_nxt;
   logic [12:0]          cause_r;
   logic [12:0]          entry_cause;
   logic                 entry;
   logic                 power_now_r;
   logic [31:0]          delay_reg_r;
   logic [DELAY_W-1:0]   delay_cnt_r;
   logic                 delay_done;
   logic                 wr_status;
   logic                 wr_delay;
   logic                 sel_status;
   logic                 sel_delay;
   logic [31:0]          rdata_nxt;

   // Refuse widths the delay register cannot hold
   if (DELAY_W < 1 || DELAY_W > scs_pkg::SCS_DLY_W)
   begin : g_bad_delay_w
      $error("scs_top: DELAY_W must lie between 1 and 20");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Picks one cause out of several that arrive together
   function automatic logic [12:0] pick_one(input logic [12:0] req);
      logic [12:0] res;
      res = '0;
      for (int i = 0; i <= scs_pkg::SCS_CAUSE_MSB; i++)
      begin
         if (req[i] && res == '0)
            res[i] = 1'b1;
      end
      return res;
   endfunction

   function automatic logic is_abnormal(input logic [12:0] c);
      return |(c & scs_pkg::SCS_ABNORMAL_MASK);
   endfunction

   // Working power stays up in Working and during a reset-type wait
   function automatic logic keeps_power(input scs_pkg::scs_state_t s);
      return (s == scs_pkg::SCS_WORKING) || (s == scs_pkg::SCS_ABN_WAIT);
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   assign sync_in = {i_events, i_slow_clk, i_wake_default, i_wake_programmed};

   scs_sync #(
      .W (SW)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_async   (sync_in),
      .o_level   (sync_out)
   );

   assign ev_lvl       = sync_out[SW-1:3];
   assign slow_lvl     = sync_out[2];
   assign wake_def_lvl = sync_out[1];
   assign wake_prg_lvl = sync_out[0];

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         ev_prev_r   <= '0;
         slow_prev_r <= 1'b0;
      end
      else
      begin
         ev_prev_r   <= ev_lvl;
         slow_prev_r <= slow_lvl;
      end
   end

   // Edge registers reset to the idle low level: no false edge after reset
   assign ev_rise   = ev_lvl & ~ev_prev_r;
   assign slow_tick = slow_lvl & ~slow_prev_r;

   // ------------------------------------------------------------
   // Entry cause selection
   // ------------------------------------------------------------
   always_comb
   begin
      logic [12:0] req;
      req                                = '0;
      req[scs_pkg::SCS_C_BAD_PACKET]  = ev_rise.bad_packet;
      req[scs_pkg::SCS_C_CTRL_SOFT]   = ev_rise.ctrl_soft;
      req[scs_pkg::SCS_C_WATCHDOG]    = ev_rise.watchdog;
      req[scs_pkg::SCS_C_SHUTDOWN]    = ev_rise.shutdown;
      req[scs_pkg::SCS_C_SOFTWARE]    = ev_rise.software;
      req[scs_pkg::SCS_C_HARD]        = ev_rise.hard;
      req[scs_pkg::SCS_C_LOW_BATTERY] = ev_rise.low_battery;
      req[scs_pkg::SCS_C_THERMAL]     = ev_rise.thermal;
      req[scs_pkg::SCS_C_BUTTON]      = ev_rise.button;
      req[scs_pkg::SCS_C_SUPPLY_LOSS] = ev_rise.supply_loss;
      req[scs_pkg::SCS_C_PLANNED]     = i_planned_sleep;
      entry_cause                     = pick_one(req);
   end

   // An edge seen outside Working is dropped, not held for later
   assign entry = (state_r == scs_pkg::SCS_WORKING) && (entry_cause != '0);

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   assign sel_status = (i_addr == scs_pkg::SCS_OFS_STATUS);
   assign sel_delay  = (i_addr == scs_pkg::SCS_OFS_ABN_DELAY);
   assign wr_status  = i_wr && sel_status;
   assign wr_delay   = i_wr && sel_delay;

   // ------------------------------------------------------------
   // Cause flags
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         cause_r <= scs_pkg::SCS_CAUSE_RESET;
      else if (entry)
         cause_r <= entry_cause;
      else if (wr_status)
         cause_r <= cause_r & ~(i_wdata[12:0] & scs_pkg::SCS_CAUSE_MASK);
   end

   // ------------------------------------------------------------
   // Power-now bit
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         power_now_r <= 1'b0;
      else if (wr_status && i_wdata[scs_pkg::SCS_BIT_PN_SET])
         power_now_r <= 1'b1;
      else if (wr_status && i_wdata[scs_pkg::SCS_BIT_PN_CLEAR])
         power_now_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // Abnormal return delay register
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         delay_reg_r <= scs_pkg::SCS_DLY_RESET;
      else if (wr_delay && !delay_reg_r[scs_pkg::SCS_BIT_DLY_LOCK])
         delay_reg_r <= i_wdata & scs_pkg::SCS_DLY_RW_MASK;
   end

   // ------------------------------------------------------------
   // Delay counter, advanced on each 32 kHz rising edge during the abnormal wait
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         delay_cnt_r <= '0;
      else if (entry)
         delay_cnt_r <= '0;
      else if (state_r == scs_pkg::SCS_ABN_WAIT && slow_tick && !delay_done)
         delay_cnt_r <= delay_cnt_r + DELAY_W'(1);
   end

   // The counter stops at the programmed count, so a long wait cannot wrap
   assign delay_done = !delay_reg_r[scs_pkg::SCS_BIT_DLY_EN]
                    || (delay_cnt_r >= delay_reg_r[DELAY_W-1:0]);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         scs_pkg::SCS_WORKING:
         begin
            if (entry && is_abnormal(entry_cause))
               state_nxt = scs_pkg::SCS_ABN_WAIT;
            else if (entry)
               state_nxt = scs_pkg::SCS_STANDBY;
         end
         scs_pkg::SCS_ABN_WAIT:
         begin
            if (delay_done && !(cause_r[scs_pkg::SCS_C_HARD] && ev_lvl.hard))
               state_nxt = scs_pkg::SCS_WORKING;
         end
         scs_pkg::SCS_STANDBY:
         begin
            if (cause_r[scs_pkg::SCS_C_PLANNED] && wake_prg_lvl)
               state_nxt = scs_pkg::SCS_WAKE_READY;
            else if (!cause_r[scs_pkg::SCS_C_PLANNED] && wake_def_lvl)
               state_nxt = scs_pkg::SCS_WAKE_READY;
         end
         scs_pkg::SCS_WAKE_READY:
         begin
            // Hold off while the low battery pin is still asserted
            if (!(cause_r[scs_pkg::SCS_C_LOW_BATTERY] && ev_lvl.low_battery))
               state_nxt = scs_pkg::SCS_WORKING;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         state_r <= scs_pkg::SCS_STANDBY;
      else
         state_r <= state_nxt;
   end

   // ------------------------------------------------------------
   // Power enables and status outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         o_working_en  <= 1'b0;
         o_work_aux_en <= 1'b0;
      end
      else
      begin
         // Reset-type standby keeps Working power up
         o_working_en  <= keeps_power(state_nxt);
         o_work_aux_en <= keeps_power(state_nxt);
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         o_standby <= 1'b1;
      else
         o_standby <= (state_nxt != scs_pkg::SCS_WORKING);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         o_power_now  <= 1'b0;
         o_last_cause <= scs_pkg::SCS_CAUSE_RESET;
      end
      else
      begin
         o_power_now  <= power_now_r;
         o_last_cause <= cause_r;
      end
   end

   // ------------------------------------------------------------
   // Read data, valid in the cycle after the strobe
   // ------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (sel_status)
      begin
         rdata_nxt[12:0] = cause_r & scs_pkg::SCS_CAUSE_MASK;
         rdata_nxt[scs_pkg::SCS_BIT_POWER_NOW] = power_now_r;
      end
      else if (sel_delay)
         rdata_nxt = delay_reg_r;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         o_rdata <= 32'h0000_0000;
      else if (i_rd)
         o_rdata <= rdata_nxt;
      else
         o_rdata <= 32'h0000_0000;
   end

endmodule

/* File: verilog/scs_pkg.sv */
/*
   Shared constants and types of the standby cause and control block.
   Assumes a single 125 MHz clock and a plain register port with byte offsets.
*/
package scs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  SCS_OFS_ABN_DELAY = 8'h50;
   localparam logic [7:0]  SCS_OFS_STATUS    = 8'h54;

   // ------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------
   localparam int          SCS_BIT_POWER_NOW = 18;
   localparam int          SCS_BIT_PN_CLEAR  = 17;
   localparam int          SCS_BIT_PN_SET    = 16;
   localparam int          SCS_CAUSE_MSB     = 12;
   localparam logic [12:0] SCS_CAUSE_MASK    = 13'h1f7f;
   localparam logic [12:0] SCS_ABNORMAL_MASK = 13'h1f40;
   localparam logic [12:0] SCS_CAUSE_RESET   = 13'h0001;

   // Cause bit positions
   localparam int          SCS_C_BAD_PACKET  = 12;
   localparam int          SCS_C_CTRL_SOFT   = 11;
   localparam int          SCS_C_WATCHDOG    = 10;
   localparam int          SCS_C_SHUTDOWN    = 9;
   localparam int          SCS_C_SOFTWARE    = 8;
   localparam int          SCS_C_HARD        = 6;
   localparam int          SCS_C_LOW_BATTERY = 5;
   localparam int          SCS_C_THERMAL     = 4;
   localparam int          SCS_C_BUTTON      = 3;
   localparam int          SCS_C_SUPPLY_LOSS = 2;
   localparam int          SCS_C_PLANNED     = 1;

   // ------------------------------------------------------------
   // Abnormal return delay register fields
   // ------------------------------------------------------------
   localparam int          SCS_BIT_DLY_LOCK  = 31;
   localparam int          SCS_BIT_DLY_EN    = 30;
   localparam int          SCS_DLY_W         = 20;
   localparam logic [31:0] SCS_DLY_RESET     = 32'h0000_0000;
   localparam logic [31:0] SCS_DLY_RW_MASK   = 32'hc00f_ffff;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          SCS_SYNC_STAGES   = 3;
   localparam int          SCS_CLK_MHZ       = 125;
   localparam int          SCS_SLOW_KHZ      = 32;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic bad_packet;
      logic ctrl_soft;
      logic watchdog;
      logic shutdown;
      logic software;
      logic hard;
      logic low_battery;
      logic thermal;
      logic button;
      logic supply_loss;
   } scs_events_t;

   typedef enum logic [1:0] {
      SCS_WORKING    = 2'b00,
      SCS_ABN_WAIT   = 2'b01,
      SCS_STANDBY    = 2'b10,
      SCS_WAKE_READY = 2'b11
   } scs_state_t;

endpackage

/* File: verilog/scs_sync.sv */
/*
   Three-stage input synchroniser with agreement filter.
   Assumes asynchronous inputs; the output changes once stages two and three agree.
*/
`timescale 1ns/1ns
module scs_sync #(
   parameter int W = 1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] meta_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   if (W < 1)
   begin : g_bad_width
      $error("scs_sync: width must be at least one");
   end

   // ------------------------------------------------------------
   // Stages
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         meta_r <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
      end
      else
      begin
         meta_r <= i_async;
         s2_r   <= meta_r;
         s3_r   <= s2_r;
      end
   end

   // ------------------------------------------------------------
   // Agreement filter
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         o_level <= '0;
      else
         o_level <= (s2_r & s3_r) | (o_level & (s2_r | s3_r));
   end

endmodule

/* File: testbench/scs_top_assertions.sv */
/*
   Port checker of the standby cause and control block.
   Assumes it is bound to scs_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module scs_top_checker #(
   parameter int DELAY_W = scs_pkg::SCS_DLY_W
) (
   input wire logic                 i_ref_clk,
   input wire logic                 i_rst_b,
   input wire logic [7:0]           i_addr,
   input wire logic [31:0]          i_wdata,
   input wire logic                 i_wr,
   input wire logic                 i_rd,
   input wire logic [31:0]          o_rdata,
   input wire scs_pkg::scs_events_t i_events,
   input wire logic                 i_planned_sleep,
   input wire logic                 i_slow_clk,
   input wire logic                 i_wake_default,
   input wire logic                 i_wake_programmed,
   input wire logic                 o_working_en,
   input wire logic                 o_work_aux_en,
   input wire logic                 o_standby,
   input wire logic                 o_power_now,
   input wire logic [12:0]          o_last_cause
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_stat_rd;
      i_rd && i_addr == scs_pkg::SCS_OFS_STATUS;
   endsequence
   sequence s_stat_wr;
      i_wr && i_addr == scs_pkg::SCS_OFS_STATUS;
   endsequence
   sequence s_entry;
      $rose(o_standby);
   endsequence

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   unmapped_read_a :
      assert property (i_rd && i_addr != scs_pkg::SCS_OFS_STATUS
         && i_addr != scs_pkg::SCS_OFS_ABN_DELAY |=> o_rdata == 32'h0)
      else $error("unmapped read returned data");
   status_reserved_a :
      assert property (s_stat_rd |=> (o_rdata & 32'hfffb_e080) == 32'h0)
      else $error("reserved status bits read nonzero");
   status_copy_a :
      assert property (s_stat_rd |=> o_rdata[18] == o_power_now
         && o_rdata[12:0] == o_last_cause)
      else $error("status read disagrees with state outputs");
   pn_set_a :
      assert property (s_stat_wr ##0 i_wdata[16] |-> ##2 o_power_now)
      else $error("power now not set");
   pn_clear_a :
      assert property (s_stat_wr ##0 (i_wdata[17:16] == 2'b10) |-> ##2 !o_power_now)
      else $error("power now not cleared");
   pn_hold_a :
      assert property (s_stat_wr ##0 (i_wdata[17:16] == 2'b00) |-> ##2 $stable(o_power_now))
      else $error("power now changed by plain write");
   entry_onehot_a :
      assert property (s_entry |=> $onehot(o_last_cause))
      else $error("entry left other than one cause");
   entry_power_a :
      assert property (s_entry |=> o_working_en == ((o_last_cause
         & scs_pkg::SCS_ABNORMAL_MASK) != 13'h0) && o_work_aux_en == o_working_en)
      else $error("power enables wrong on entry");
   cause_clear_a :
      assert property (s_stat_wr ##1 $stable(o_standby) ##1 $stable(o_standby)
         |-> (o_last_cause & $past(i_wdata[12:0], 2)) == 13'h0)
      else $error("cause flag not cleared by write");
endmodule

bind scs_top scs_top_checker #(.DELAY_W(DELAY_W)) scs_top_checker_inst (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(i_events),
   .i_planned_sleep(i_planned_sleep), .i_slow_clk(i_slow_clk),
   .i_wake_default(i_wake_default), .i_wake_programmed(i_wake_programmed),
   .o_working_en(o_working_en), .o_work_aux_en(o_work_aux_en), .o_standby(o_standby),
   .o_power_now(o_power_now), .o_last_cause(o_last_cause)
);

/* File: testbench/tb_top.sv */
/*
   Self-checking testbench of the standby cause and control block.
   Assumes scs_top with its bound checker; the slow tick pin runs fast to keep the run short.
*/
`timescale 1ns/1ns
module tb_top;
   logic                 i_ref_clk = 1'b0;
   logic                 i_rst_b = 1'b0;
   logic [7:0]           i_addr = 8'h00;
   logic [31:0]          i_wdata = 32'h0;
   logic                 i_wr = 1'b0;
   logic                 i_rd = 1'b0;
   logic [31:0]          o_rdata;
   scs_pkg::scs_events_t i_events = '0;
   logic                 i_planned_sleep = 1'b0;
   logic                 i_slow_clk = 1'b0;
   logic                 i_wake_default = 1'b0;
   logic                 i_wake_programmed = 1'b0;
   logic                 o_working_en;
   logic                 o_work_aux_en;
   logic                 o_standby;
   logic                 o_power_now;
   logic [12:0]          o_last_cause;
   logic [4:0]           slow_div_r = 5'h00;
   int                   error_cnt = 0;
   int                   comparisons = 0;
   int                   cause_bit [0:9] = '{2, 3, 4, 5, 6, 8, 9, 10, 11, 12};
   bit                   abn;
   localparam logic [7:0] ST = scs_pkg::SCS_OFS_STATUS;

   always #4 i_ref_clk = ~i_ref_clk;

   // Slow tick pin: one rising edge every 32 clock cycles
   always @(posedge i_ref_clk)
   begin
      slow_div_r <= slow_div_r + 5'h01;
      i_slow_clk <= slow_div_r[4];
   end

   scs_top scs_top_inst (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(i_events),
      .i_planned_sleep(i_planned_sleep), .i_slow_clk(i_slow_clk),
      .i_wake_default(i_wake_default), .i_wake_programmed(i_wake_programmed),
      .o_working_en(o_working_en), .o_work_aux_en(o_work_aux_en), .o_standby(o_standby),
      .o_power_now(o_power_now), .o_last_cause(o_last_cause)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask

   task automatic wait_sb(input logic v);
      int n;
      n = 0;
      while (o_standby !== v && n < 400)
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      check({31'h0, o_standby}, {31'h0, v});
   endtask

   task automatic wake(input logic prog);
      @(posedge i_ref_clk);
      i_wake_programmed <= prog;
      i_wake_default <= !prog;
      repeat (10) @(posedge i_ref_clk);
      i_wake_programmed <= 1'b0;
      i_wake_default <= 1'b0;
   endtask

   task automatic conclude();
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      rd(ST, 32'h0000_0001);
      rd(scs_pkg::SCS_OFS_ABN_DELAY, 32'h0);
      rd(8'h58, 32'h0);
      wake(1'b0);
      wait_sb(1'b0);
      check({31'h0, o_working_en}, 32'h1);
      wr(ST, 32'hffff_ffff);
      rd(ST, 32'h0004_0000);
      wr(ST, 32'h0002_0000);
      rd(ST, 32'h0);
      wr(ST, 32'h0004_0000);
      rd(ST, 32'h0);
      wr(ST, 32'h0001_0000);
      rd(ST, 32'h0004_0000);
      check({31'h0, o_power_now}, 32'h1);
      wr(scs_pkg::SCS_OFS_ABN_DELAY, 32'h4000_0002);
      rd(scs_pkg::SCS_OFS_ABN_DELAY, 32'h4000_0002);
      for (int i = 0; i < 10; i++)
      begin
         abn = cause_bit[i] == 6 || cause_bit[i] > 7;
         @(posedge i_ref_clk);
         i_events <= scs_pkg::scs_events_t'(10'h001 << i);
         wait_sb(1'b1);
         check({31'h0, o_working_en}, {31'h0, abn});
         check({31'h0, o_work_aux_en}, {31'h0, abn});
         repeat (cause_bit[i] == 6 ? 150 : 20) @(posedge i_ref_clk);
         #1;
         check({31'h0, o_standby}, 32'h1);
         rd(ST, 32'h0004_0000 | (32'h1 << cause_bit[i]));
         check({19'h0, o_last_cause}, 32'h1 << cause_bit[i]);
         @(posedge i_ref_clk);
         i_events <= '0;
         if (!abn)
            wake(1'b0);
         wait_sb(1'b0);
         wr(ST, 32'h0);
      end
      @(posedge i_ref_clk);
      i_planned_sleep <= 1'b1;
      @(posedge i_ref_clk);
      i_planned_sleep <= 1'b0;
      wait_sb(1'b1);
      check({31'h0, o_working_en}, 32'h0);
      check({31'h0, o_work_aux_en}, 32'h0);
      wake(1'b0);
      repeat (20) @(posedge i_ref_clk);
      #1;
      check({31'h0, o_standby}, 32'h1);
      wake(1'b1);
      wait_sb(1'b0);
      rd(ST, 32'h0004_0002);
      @(posedge i_ref_clk);
      i_events <= scs_pkg::scs_events_t'(10'h006);
      wait_sb(1'b1);
      @(posedge i_ref_clk);
      i_events <= '0;
      rd(ST, 32'h0004_0008);
      wake(1'b0);
      wait_sb(1'b0);
      wr(ST, 32'h0000_0008);
      rd(ST, 32'h0004_0000);
      check({19'h0, o_last_cause}, 32'h0);
      conclude();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (30000) @(posedge i_ref_clk);
      error_cnt++;
      conclude();
   end
endmodule
